// ===== hdl/pcs_map.svh
// register offsets, field positions, reset values and widths of the program counter block
`ifndef PCS_MAP_SVH
`define PCS_MAP_SVH

// ---------------------------------------------------------------
// register byte offsets on the avalon slave
// ---------------------------------------------------------------
`define PCS_ADDR_W 4
`define PCS_OFF_LOW 4'h0
`define PCS_OFF_LATCH 4'h4

// ---------------------------------------------------------------
// field widths and positions
// ---------------------------------------------------------------
`define PCS_PC_W 13
`define PCS_LOW_W 8
`define PCS_LATCH_W 5
`define PCS_TARGET_W 11
`define PCS_PAGE_MSB 4
`define PCS_PAGE_LSB 3
`define PCS_STACK_DEPTH 8

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define PCS_PC_RST 13'h0000
`define PCS_LATCH_RST 5'h00
`define PCS_VECTOR_DEF 13'h0004

`endif

// ===== hdl/pcs_pkg.sv
// types shared by the program counter and return stack block
package pcs_pkg;

  // ---------------------------------------------------------------
  // operation kinds issued by the instruction decoder
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    PCS_OP_ADVANCE = 3'h0,   // plain fetch, next word
    PCS_OP_JUMP = 3'h1,      // direct_jump_op
    PCS_OP_CALL = 3'h2,      // subroutine jump, pushes return address
    PCS_OP_RETURN = 3'h3,    // subroutine exit
    PCS_OP_RETLIT = 3'h4,    // exit_with_literal_op
    PCS_OP_RETINT = 3'h5,    // interrupt_exit_op
    PCS_OP_VECTOR = 3'h6,    // interrupt forces branch to vector
    PCS_OP_ADDLOW = 3'h7     // add_to_register_op on the low byte
  } pcs_op_kind_t;

  // one decoder request, valid for one cycle
  typedef struct packed {
    logic valid;
    pcs_op_kind_t kind;
    logic [10:0] target;     // jump / call address field
    logic [7:0] offset;      // addend for computed jump
  } pcs_op_t;

  // ---------------------------------------------------------------
  // avalon slave handshake states (gray along the path)
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    PCS_BUS_IDLE = 2'h0,
    PCS_BUS_ACK = 2'h1
  } pcs_bus_st_t;

endpackage : pcs_pkg

// ===== hdl/pcs_stack.sv
// circular hardware return stack for the program counter block
`timescale 1ns/1ps
`include "pcs_map.svh"

module pcs_stack #(
  parameter int DEPTH = `PCS_STACK_DEPTH,
  parameter int WIDTH = `PCS_PC_W
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_push,
  input wire logic i_pop,
  input wire logic [WIDTH-1:0] i_data,
  output logic [WIDTH-1:0] o_top
);

  localparam int PW = $clog2(DEPTH);

  // ---------------------------------------------------------------
  // storage and pointer
  // ---------------------------------------------------------------
  logic [WIDTH-1:0] mem_ff [DEPTH];   // saved return addresses
  logic [PW-1:0] ptr_ff;              // next free slot, wraps freely
  logic [PW-1:0] top_idx;             // slot of the last push

  // pointer wraps with no overflow or underflow flag by design
  assign top_idx = ptr_ff - PW'(1);
  assign o_top = mem_ff[top_idx];

  // pointer moves on push and pop; it is never visible to software
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ptr_ff <= '0;
    end else if (i_push) begin
      ptr_ff <= ptr_ff + PW'(1);
    end else if (i_pop) begin
      ptr_ff <= top_idx;
    end
  end

  // ninth push lands on the first slot again, overwriting it
  always_ff @(posedge i_clk) begin
    if (i_push) begin
      mem_ff[ptr_ff] <= i_data;
    end
  end

endmodule : pcs_stack

// ===== hdl/pcs_top.sv
// program counter with high latch, paging and circular return stack
//
// The address map and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/1ps
`include "pcs_map.svh"

// Overview of operation
// - 13-bit counter, low byte software read/write
// - upper counter bits never readable by software
// - every reset clears the upper counter bits
// - low byte write loads latch bits four:zero
// - jumps take 11 bits plus latch page bits
// - one 8K space split into 2K pages
// - return stack eight deep, thirteen bits wide
// - stack pointer hidden from software entirely
// - call and interrupt vector push counter
// - all three exit operations pop counter
// - push and pop leave latch untouched
// - stack circular, ninth push overwrites first
// - no overflow or underflow status anywhere
// - full 13-bit counter pushed and restored
module pcs_top #(
  parameter logic [12:0] VECTOR = `PCS_VECTOR_DEF,  // interrupt entry address
  parameter int STACK_DEPTH = `PCS_STACK_DEPTH      // return stack levels
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  // decoder side
  input wire pcs_pkg::pcs_op_t i_op,
  output logic o_core_stall,
  output logic [12:0] o_pc,
  // avalon-mm slave
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest
);
  import pcs_pkg::*;

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [12:0] pc_ff;            // program counter
  logic [4:0] latch_ff;          // pc_high_latch
  pcs_bus_st_t bus_ff;           // slave handshake state
  pcs_bus_st_t nxt_bus;          // next handshake state
  logic wait_ff;                 // waitrequest, high unless answering
  logic stall_ff;                // tells decoder to hold its op
  logic [31:0] rdata_ff;         // read data, stands in answer cycle
  logic bus_req;                 // read or write is being requested
  logic commit;                  // answer cycle, access takes effect
  logic wr_low;                  // software writes pc_low_byte
  logic wr_latch;                // software writes pc_high_latch
  logic op_go;                   // decoder op accepted this cycle
  logic do_push;                 // stack push this cycle
  logic do_pop;                  // stack pop this cycle
  logic [12:0] push_data;        // address saved on push
  logic [12:0] stack_top;        // address restored on pop

  // ---------------------------------------------------------------
  // helper functions
  // ---------------------------------------------------------------
  // next sequential word, wraps at the top of the 8K space
  function automatic logic [12:0] f_inc(input logic [12:0] pc);
    f_inc = pc + 13'h0001;
  endfunction : f_inc

  // page bits from the latch above an 11-bit in-page address
  function automatic logic [12:0] f_page(input logic [4:0] lat, input logic [10:0] tgt);
    f_page = {lat[`PCS_PAGE_MSB:`PCS_PAGE_LSB], tgt};
  endfunction : f_page

  // all latch bits sit above a new low byte
  // a computed jump reuses this, so a table crossing a block edge lands in the latch page
  function automatic logic [12:0] f_low(input logic [4:0] lat, input logic [7:0] low);
    f_low = {lat, low};
  endfunction : f_low

  // ---------------------------------------------------------------
  // avalon slave handshake
  // ---------------------------------------------------------------
  assign bus_req = i_avs_read | i_avs_write;
  assign commit = (bus_ff == PCS_BUS_ACK);
  assign wr_low = commit & i_avs_write & i_avs_byteenable[0]
                  & (i_avs_address == `PCS_OFF_LOW);
  assign wr_latch = commit & i_avs_write & i_avs_byteenable[0]
                    & (i_avs_address == `PCS_OFF_LATCH);

  // one wait cycle: seen in idle, answered in the next cycle
  always_comb begin
    nxt_bus = bus_ff;
    case (bus_ff)
      PCS_BUS_IDLE: begin
        if (bus_req) begin
          nxt_bus = PCS_BUS_ACK;
        end
      end
      PCS_BUS_ACK: begin
        nxt_bus = PCS_BUS_IDLE;  // master releases at this edge
      end
      default: begin
        nxt_bus = PCS_BUS_IDLE;
      end
    endcase
  end

  // handshake state register
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      bus_ff <= PCS_BUS_IDLE;
    end else begin
      bus_ff <= nxt_bus;
    end
  end

  // waitrequest drops only in the answer cycle; high through reset
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wait_ff <= 1'b1;
    end else begin
      wait_ff <= (nxt_bus != PCS_BUS_ACK);
    end
  end

  // decoder is held off in the answer cycle so the two never race
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      stall_ff <= 1'b0;
    end else begin
      stall_ff <= (nxt_bus == PCS_BUS_ACK);
    end
  end

  // read data captured at request; upper counter bits never appear
  // and the stack pointer has no address at all
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rdata_ff <= 32'h0000_0000;
    end else if (bus_ff == PCS_BUS_IDLE && i_avs_read) begin
      case (i_avs_address)
        `PCS_OFF_LOW: begin
          rdata_ff <= {24'h00_0000, pc_ff[7:0]};
        end
        `PCS_OFF_LATCH: begin
          rdata_ff <= {27'h000_0000, latch_ff};
        end
        default: begin
          rdata_ff <= 32'h0000_0000;  // unmapped
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // high latch
  // ---------------------------------------------------------------
  // only software writes it; stack traffic never touches it
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      latch_ff <= `PCS_LATCH_RST;
    end else if (wr_latch) begin
      latch_ff <= i_avs_writedata[4:0];
    end
  end

  // ---------------------------------------------------------------
  // program counter sequencing
  // ---------------------------------------------------------------
  // an op arriving in an answer cycle is dropped: decoder must hold
  // limitation: each bus access costs the core one issue slot
  assign op_go = i_op.valid & ~stall_ff;

  // push and pop strobes for the return stack
  always_comb begin
    do_push = 1'b0;
    do_pop = 1'b0;
    push_data = pc_ff;
    if (op_go) begin
      case (i_op.kind)
        PCS_OP_CALL: begin
          do_push = 1'b1;
          push_data = f_inc(pc_ff);
        end
        PCS_OP_VECTOR: begin
          do_push = 1'b1;            // interrupted word re-executes
          push_data = pc_ff;
        end
        PCS_OP_RETURN, PCS_OP_RETLIT, PCS_OP_RETINT: begin
          do_pop = 1'b1;
        end
        default: begin
          do_push = 1'b0;
        end
      endcase
    end
  end

  // counter update; a software write of the low byte wins the cycle
  // because the decoder is stalled whenever it can occur
  // trade-off: one stall cycle buys a counter with a single writer per edge
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pc_ff <= `PCS_PC_RST;
    end else if (wr_low) begin
      pc_ff <= f_low(latch_ff, i_avs_writedata[7:0]);
    end else if (op_go) begin
      case (i_op.kind)
        PCS_OP_ADVANCE: begin
          pc_ff <= f_inc(pc_ff);
        end
        PCS_OP_JUMP, PCS_OP_CALL: begin
          pc_ff <= f_page(latch_ff, i_op.target);
        end
        PCS_OP_RETURN, PCS_OP_RETLIT, PCS_OP_RETINT: begin
          pc_ff <= stack_top;
        end
        PCS_OP_VECTOR: begin
          pc_ff <= VECTOR;
        end
        PCS_OP_ADDLOW: begin
          // sum wraps in the low byte; no carry into the page bits
          pc_ff <= f_low(latch_ff, pc_ff[7:0] + i_op.offset);
        end
        default: begin
          pc_ff <= f_inc(pc_ff);
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // return stack
  // ---------------------------------------------------------------
  // pointer lives inside; no flags leave it
  // storage is not reset: stale slots only show after an unbalanced pop
  pcs_stack #(
    .DEPTH(STACK_DEPTH),
    .WIDTH(13)
  ) u_stack (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_push(do_push),
    .i_pop(do_pop),
    .i_data(push_data),
    .o_top(stack_top)
  );

  // ---------------------------------------------------------------
  // outputs, all straight from flip-flops
  // ---------------------------------------------------------------
  assign o_pc = pc_ff;
  assign o_core_stall = stall_ff;
  assign o_avs_readdata = rdata_ff;
  assign o_avs_waitrequest = wait_ff;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  // helper: op kind and strobe one cycle old
  logic prev_go;
  pcs_op_kind_t prev_kind;
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      prev_go <= 1'b0;
      prev_kind <= PCS_OP_ADVANCE;
    end else begin
      prev_go <= op_go & ~wr_low;
      prev_kind <= i_op.kind;
    end
  end

  low_write_load_a: assert property (
    wr_low |=> pc_ff == {$past(latch_ff), $past(i_avs_writedata[7:0])})
    else $error("low byte write did not load the latch bits");

  jump_page_a: assert property (
    op_go && !wr_low && i_op.kind inside {PCS_OP_JUMP, PCS_OP_CALL}
    |=> pc_ff[12:11] == $past(latch_ff[4:3]) && pc_ff[10:0] == $past(i_op.target))
    else $error("jump did not use page bits and target");

  advance_wrap_a: assert property (
    prev_go && prev_kind == PCS_OP_ADVANCE |-> pc_ff == $past(pc_ff) + 13'h0001)
    else $error("counter did not advance by one");

  pop_restore_a: assert property (
    op_go && !wr_low && i_op.kind inside {PCS_OP_RETURN, PCS_OP_RETLIT, PCS_OP_RETINT}
    |=> pc_ff == $past(stack_top))
    else $error("exit did not restore stack top");

  latch_kept_a: assert property (
    (do_push || do_pop) && !wr_latch |=> $stable(latch_ff))
    else $error("stack traffic changed the latch");

  call_return_a: assert property (
    op_go && !wr_low && i_op.kind == PCS_OP_CALL
    ##1 op_go && !wr_low && i_op.kind == PCS_OP_RETURN
    |=> pc_ff == $past(pc_ff, 2) + 13'h0001)
    else $error("call then return lost the full address");

  vector_entry_a: assert property (
    op_go && !wr_low && i_op.kind == PCS_OP_VECTOR
    |=> pc_ff == VECTOR && stack_top == $past(pc_ff))
    else $error("interrupt did not reach its vector");

  read_hides_high_a: assert property (
    !wait_ff |-> rdata_ff[31:8] == 24'h00_0000
    && (!i_avs_read || i_avs_address != `PCS_OFF_LOW || rdata_ff[7:0] == $past(pc_ff[7:0])))
    else $error("read data exposed upper bits");

  answer_pulse_a: assert property (
    bus_req && wait_ff && bus_ff == PCS_BUS_IDLE |=> !wait_ff && stall_ff ##1 wait_ff)
    else $error("waitrequest answer not one cycle");

  reset_clear_a: assert property (@(posedge i_clk) disable iff (1'b0)
    $rose(i_resetn) |-> pc_ff[12:8] == 5'h00 && latch_ff == `PCS_LATCH_RST)
    else $error("reset left upper counter bits set");

  call_push_a: assert property (
    op_go && !wr_low && i_op.kind == PCS_OP_CALL |=> stack_top == $past(pc_ff) + 13'h0001)
    else $error("call did not push the next address");

  push_full_a: assert property (
    do_push |=> stack_top == $past(push_data))
    else $error("pushed address not kept in full");

  // ---------------------------------------------------------------
  // covers
  // ---------------------------------------------------------------
  call_cov: cover property (op_go && i_op.kind == PCS_OP_CALL);
  vector_cov: cover property (op_go && i_op.kind == PCS_OP_VECTOR ##[1:20] do_pop);
  low_write_cov: cover property (wr_low);
  addlow_cov: cover property (op_go && i_op.kind == PCS_OP_ADDLOW);
  call_return_cov: cover property (op_go && i_op.kind == PCS_OP_CALL ##1 op_go && i_op.kind == PCS_OP_RETURN);

endmodule : pcs_top

// ===== tb/pcs_decoder_model.sv
// decoder model that feeds operations to the program counter block
`timescale 1ns/1ps

module pcs_decoder_model (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire pcs_pkg::pcs_op_t i_req,
  input wire logic i_stall,
  output pcs_pkg::pcs_op_t o_op
);
  import pcs_pkg::*;
  // ---------------------------------------------------------------
  // operation issue
  // ---------------------------------------------------------------
  // the real decoder withholds ops during the bus answer cycle and in
  // reset; page bits are set by the bench before jumps
  always_comb begin
    if (i_stall || !i_resetn) begin  // withhold, a dropped op would be lost
      o_op = '0;
    end else begin  // offsets may cross a 256-word block
      o_op = i_req;
    end
  end
endmodule : pcs_decoder_model

// ===== tb/pcs_tb_top.sv
// self-checking bench for the program counter and return stack block
`timescale 1ns/1ps
`include "pcs_map.svh"

`define CHK(what, exp, got) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
      n_mismatch++; \
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got); \
    end \
  end

module pcs_tb_top;
  import pcs_pkg::*;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  localparam logic [12:0] VEC = 13'h1234;  // entry address, distinct from reset
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;  // active low
  pcs_op_t req;  // bench request to the decoder model
  pcs_op_t op;  // what the model hands the block
  logic stall;
  logic [12:0] pc;
  logic [3:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  int n_mismatch = 0;
  int total_checks = 0;
  logic [12:0] saved [0:8];  // return addresses, in push order
  logic [12:0] p;
  logic [31:0] rd;

  always #2 i_clk = ~i_clk;  // 250 MHz

  pcs_decoder_model pcs_decoder_model_i (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_req(req),
    .i_stall(stall),
    .o_op(op)
  );

  pcs_top #(.VECTOR(VEC)) pcs_top_i (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_op(op),
    .o_core_stall(stall),
    .o_pc(pc),
    .i_avs_address(avs_address),
    .i_avs_read(avs_read),
    .i_avs_write(avs_write),
    .i_avs_writedata(avs_writedata),
    .i_avs_byteenable(avs_byteenable),
    .o_avs_readdata(avs_readdata),
    .o_avs_waitrequest(avs_waitrequest)
  );

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  // closing report, reached from the end of the run or a timeout
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict

  // one avalon access; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] addr, input logic [31:0] wdata,
                     input logic [3:0] be, output logic [31:0] rdata);
    int n;
    n = 0;
    @(posedge i_clk);
    avs_address <= addr;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= wdata;
    avs_byteenable <= be;
    do begin
      @(posedge i_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rdata = avs_readdata;
    `CHK("stall in answer", 1'b1, stall)
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    #1;
    if (n >= 20) begin  // bus hang counts as a mismatch
      n_mismatch++;
      give_verdict();
    end
  endtask : bus

  task automatic wr_reg(input logic [3:0] addr, input logic [31:0] wdata);
    bus(1'b1, addr, wdata, 4'hF, rd);
  endtask : wr_reg

  // one decoder op; the new counter is settled on return
  task automatic do_op(input pcs_op_kind_t kind, input logic [10:0] tgt,
                       input logic [7:0] off);
    @(posedge i_clk);
    req <= '{valid: 1'b1, kind: kind, target: tgt, offset: off};
    @(posedge i_clk);
    req.valid <= 1'b0;
    #1;
  endtask : do_op

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    req = '0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    repeat (5) @(posedge i_clk);
    i_resetn <= 1'b1;
    #1;
    `CHK("pc after reset", 13'h0000, pc)
    // low byte write pulls in all five latch bits
    wr_reg(`PCS_OFF_LATCH, 32'h0000_0015);
    wr_reg(`PCS_OFF_LOW, 32'h0000_00AB);
    `CHK("pc after low write", 13'h15AB, pc)
    bus(1'b0, `PCS_OFF_LOW, 32'h0, 4'hF, rd);
    `CHK("low byte read", 32'h0000_00AB, rd)
    bus(1'b0, 4'h8, 32'h0, 4'hF, rd);
    `CHK("unmapped read", 32'h0000_0000, rd)
    bus(1'b1, `PCS_OFF_LOW, 32'h0000_0011, 4'h0, rd);
    `CHK("masked write", 13'h15AB, pc)
    // advance and wrap at the top of the 8K space
    wr_reg(`PCS_OFF_LATCH, 32'h0000_001F);
    wr_reg(`PCS_OFF_LOW, 32'h0000_00FF);
    do_op(PCS_OP_ADVANCE, 11'h000, 8'h00);
    `CHK("advance wrap", 13'h0000, pc)
    do_op(PCS_OP_ADVANCE, 11'h000, 8'h00);
    `CHK("advance", 13'h0001, pc)
    // direct jump into each 2K page; latch bits 2:0 must not leak in
    for (int pg = 0; pg < 4; pg++) begin
      wr_reg(`PCS_OFF_LATCH, {27'h0, pg[1:0], 3'b111});
      do_op(PCS_OP_JUMP, 11'h5A5, 8'h00);
      `CHK("jump page", {pg[1:0], 11'h5A5}, pc)
    end
    // call to another page and back restores the full address
    wr_reg(`PCS_OFF_LATCH, 32'h0000_0008);
    p = pc + 13'h0001;
    do_op(PCS_OP_CALL, 11'h100, 8'h00);
    `CHK("call", 13'h0900, pc)
    do_op(PCS_OP_RETURN, 11'h000, 8'h00);
    `CHK("return", p, pc)
    bus(1'b0, `PCS_OFF_LATCH, 32'h0, 4'hF, rd);
    `CHK("latch after pop", 32'h0000_0008, rd)
    // nine calls overrun the eight levels; pops use every exit kind
    for (int i = 0; i < 9; i++) begin
      saved[i] = pc + 13'h0001;
      do_op(PCS_OP_CALL, 11'h010 + 11'(i), 8'h00);
      `CHK("nested call", {2'b01, 11'h010 + 11'(i)}, pc)
    end
    for (int i = 0; i < 9; i++) begin
      do_op(pcs_op_kind_t'(3 + i % 3), 11'h000, 8'h00);
      `CHK("circular pop", (i < 8) ? saved[8 - i] : saved[8], pc)
    end
    // interrupt entry pushes the current counter
    p = pc;
    do_op(PCS_OP_VECTOR, 11'h000, 8'h00);
    `CHK("vector", VEC, pc)
    do_op(PCS_OP_RETINT, 11'h000, 8'h00);
    `CHK("interrupt exit", p, pc)
    // call and return on adjacent edges, valid held high between them
    wr_reg(`PCS_OFF_LATCH, 32'h0000_0008);
    p = pc + 13'h0001;
    @(posedge i_clk);
    req <= '{valid: 1'b1, kind: PCS_OP_CALL, target: 11'h222, offset: 8'h00};
    @(posedge i_clk);
    req.kind <= PCS_OP_RETURN;
    @(posedge i_clk);
    req.valid <= 1'b0;
    #1;
    `CHK("call then return", p, pc)
    // computed jump over a 256-word block does not carry upward
    wr_reg(`PCS_OFF_LATCH, 32'h0000_0003);
    wr_reg(`PCS_OFF_LOW, 32'h0000_00F0);
    wr_reg(`PCS_OFF_LATCH, 32'h0000_0005);
    do_op(PCS_OP_ADDLOW, 11'h000, 8'h20);
    `CHK("computed jump", 13'h0510, pc)
    // reset in mid-run clears the upper bits and the latch
    @(posedge i_clk);
    i_resetn <= 1'b0;
    repeat (2) @(posedge i_clk);
    `CHK("pc in reset", 13'h0000, pc)
    i_resetn <= 1'b1;
    bus(1'b0, `PCS_OFF_LATCH, 32'h0, 4'hF, rd);
    `CHK("latch after reset", 32'h0000_0000, rd)
    give_verdict();
  end
endmodule : pcs_tb_top
